// ===== common/gpx_pkg.sv
// package: register map, field layout and timing constants of the pin port
package gpx_pkg;
	// bus and register geometry
	localparam int ADDR_W = 8;
	localparam int DATA_W = 32;
	localparam int STRB_W = DATA_W / 8;
	localparam int CTRL_W = 24;
	localparam int NPINS = 4;
	localparam int AUX_PINS = 3;
	localparam logic [ADDR_W-1:0] PORT_CTRL_IDX = 8'h06;
	localparam logic [ADDR_W-1:0] PORT_CTRL_ADDR = 8'(PORT_CTRL_IDX * 4);
	localparam logic [CTRL_W-1:0] PORT_CTRL_RESET = 24'h000000;
	// software-writable bits; input bits and reserved bits excluded
	localparam logic [CTRL_W-1:0] PORT_CTRL_WR_MASK = 24'h05EEEE;
	// per-pin field layout: pin n occupies bits 4n+3 .. 4n
	localparam int PIN_STRIDE = 4;
	localparam int STATE_OFS = 2;
	localparam int OUT_OFS = 1;
	localparam int IN_OFS = 0;
	localparam int AUX_ENABLE_BIT = 16;
	localparam int AUX_FRAMING_BIT = 18;
	// pin state encodings
	localparam logic [1:0] PIN_HIZ = 2'h0;
	localparam logic [1:0] PIN_INPUT = 2'h1;
	localparam logic [1:0] PIN_PUSH = 2'h2;
	localparam logic [1:0] PIN_DRAIN = 2'h3;
	// bus responses
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	// auxiliary serial stream timing
	localparam int AUX_RATE_HZ = 128000;
	localparam int LINK_PERIOD_NS = 15;
	localparam int RATE_CNT = 1000000000 / (AUX_RATE_HZ * LINK_PERIOD_NS);
	localparam int RATE_W = 10;
	localparam int WORD_W = 32;
	localparam int BIT_W = 5;
	localparam int FRAME_WORDS = 4;
	localparam int WCNT_W = 2;
	localparam int GAP_CYC = 4;
	localparam int GAP_W = 2;
	// link-side copy of configuration: {ce, framing, enable, 3 x {state,out}}
	localparam int CFG_W = 3 + 3 * AUX_PINS;
	// link sequencer states
	typedef enum logic [2:0] {
		LS_IDLE  = 3'h1,
		LS_SHIFT = 3'h2,
		LS_GAP   = 3'h4
	} gpx_lstate_t;
endpackage

// ===== hdl/gpx_port.sv
// four-pin port with auxiliary serial stream, AXI4-Lite register access
//
// Notes on behaviour
// - state field: 00 high impedance, 01 input, 10 push-pull, 11 open drain
// - pin 3 uses state bits 15:14, output bit 13, input bit 12
// - pin 2 uses state bits 11:10, output bit 9, input bit 8
// - pin 1 uses state bits 7:6, output bit 5, input bit 4
// - pin 0 uses state bits 3:2, output bit 1, input bit 0
// - push-pull drives the output value bit level; open drain drives low for 0 and releases for 1
// - in input state the input bit reads the sampled pin level
// - input bits are read only; writes leave them unchanged
// - enable bit 16 turns pins 0-2 into a 128 kHz ECG stream
// - while the stream is on, pins 0-2 ignore their own control bits
// - pin 3 always follows its own control bits
// - framing bit 18: chip select per frame when clear, per word when set
// - control register resets to all zeros
//
// The AXI4-Lite interface to the registers was left to the implementer.
`timescale 1ns/100ps
module gpx_port
	import gpx_pkg::*;
(
	// clocks, reset, freeze
	input  wire logic              clock,
	input  wire logic              nrst,
	input  wire logic              ce,
	input  wire logic              link_clk,
	// axi4-lite write address and data
	input  wire logic [ADDR_W-1:0] s_axi_awaddr,
	input  wire logic              s_axi_awvalid,
	output logic                   s_axi_awready,
	input  wire logic [DATA_W-1:0] s_axi_wdata,
	input  wire logic [STRB_W-1:0] s_axi_wstrb,
	input  wire logic              s_axi_wvalid,
	output logic                   s_axi_wready,
	// axi4-lite write response
	output logic [1:0]             s_axi_bresp,
	output logic                   s_axi_bvalid,
	input  wire logic              s_axi_bready,
	// axi4-lite read
	input  wire logic [ADDR_W-1:0] s_axi_araddr,
	input  wire logic              s_axi_arvalid,
	output logic                   s_axi_arready,
	output logic [DATA_W-1:0]      s_axi_rdata,
	output logic [1:0]             s_axi_rresp,
	output logic                   s_axi_rvalid,
	input  wire logic              s_axi_rready,
	// ecg word source
	input  wire logic [WORD_W-1:0] ecg_data,
	input  wire logic              ecg_valid,
	output logic                   ecg_ready,
	// general pins
	input  wire logic [NPINS-1:0]  pin_in,
	output logic [NPINS-1:0]       pin_out,
	output logic [NPINS-1:0]       pin_oe_n
);

	// pin driver: returns {level, oe_n} for a state and output value
	function automatic logic [1:0] pin_drive(input logic [1:0] st,
		input logic val);
		logic [1:0] r;
		r = 2'h1;
		case (st)
			PIN_PUSH:  r = {val, 1'b0};
			PIN_DRAIN: r = {1'b0, val};
			default:   r = 2'h1;
		endcase
		return r;
	endfunction

	// word-aligned address match against the control register
	function automatic logic hit(input logic [ADDR_W-1:0] a);
		return a[ADDR_W-1:2] == PORT_CTRL_ADDR[ADDR_W-1:2];
	endfunction

	// main-domain state
	logic [CTRL_W-1:0]  ctrl_ff;
	logic [NPINS-1:0]   in_ff;
	logic [NPINS-1:0]   ps1_ff;
	logic [NPINS-1:0]   ps2_ff;
	logic [NPINS-1:0]   ps3_ff;
	logic [NPINS-1:0]   pfilt_ff;
	logic               aw_held_ff;
	logic               w_held_ff;
	logic [ADDR_W-1:0]  waddr_ff;
	logic [DATA_W-1:0]  wdata_ff;
	logic [STRB_W-1:0]  wstrb_ff;
	logic               awready_ff;
	logic               wready_ff;
	logic               bvalid_ff;
	logic [1:0]         bresp_ff;
	logic               arready_ff;
	logic               rvalid_ff;
	logic [DATA_W-1:0]  rdata_ff;
	logic [1:0]         rresp_ff;
	logic               p3_out_ff;
	logic               p3_oe_n_ff;
	logic [WORD_W-1:0]  hold_ff;
	logic               req_tgl_ff;
	logic               ready_ff;
	logic               as1_ff;
	logic               as2_ff;
	logic               as3_ff;
	logic               ack_seen_ff;
	// link-side echo of the request toggle, read back through as1_ff
	logic               ack_tgl_ff;
	logic [CFG_W-1:0]   cfg_src;
	logic [DATA_W-1:0]  rd_word;
	logic               aux_en;
	logic               ecg_take;
	logic               nxt_req_tgl;
	logic               nxt_ack_seen;

	assign aux_en = ctrl_ff[AUX_ENABLE_BIT];

	// register image as read: inputs appear at their own positions
	always_comb begin
		rd_word = '0;
		rd_word[CTRL_W-1:0] = ctrl_ff & PORT_CTRL_WR_MASK;
		for (int i = 0; i < NPINS; i++) begin
			rd_word[i*PIN_STRIDE+IN_OFS] = in_ff[i];
		end
	end

	// write address channel; readiness returns only after the response
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			aw_held_ff <= 1'b0;
			awready_ff <= 1'b1;
			waddr_ff   <= '0;
		end else if (ce) begin
			if (s_axi_awvalid && awready_ff) begin
				aw_held_ff <= 1'b1;
				awready_ff <= 1'b0;
				waddr_ff   <= s_axi_awaddr;
			end else if (aw_held_ff && w_held_ff && !bvalid_ff) begin
				aw_held_ff <= 1'b0;
			end else if (bvalid_ff && s_axi_bready) begin
				awready_ff <= 1'b1;
			end
		end
	end

	// write data channel, taken independently of the address
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			w_held_ff <= 1'b0;
			wready_ff <= 1'b1;
			wdata_ff  <= '0;
			wstrb_ff  <= '0;
		end else if (ce) begin
			if (s_axi_wvalid && wready_ff) begin
				w_held_ff <= 1'b1;
				wready_ff <= 1'b0;
				wdata_ff  <= s_axi_wdata;
				wstrb_ff  <= s_axi_wstrb;
			end else if (aw_held_ff && w_held_ff && !bvalid_ff) begin
				w_held_ff <= 1'b0;
			end else if (bvalid_ff && s_axi_bready) begin
				wready_ff <= 1'b1;
			end
		end
	end

	// write response follows once both halves are held
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			bvalid_ff <= 1'b0;
			bresp_ff  <= RESP_OKAY;
		end else if (ce) begin
			if (aw_held_ff && w_held_ff && !bvalid_ff) begin
				bvalid_ff <= 1'b1;
				bresp_ff  <= hit(waddr_ff) ? RESP_OKAY : RESP_SLVERR;
			end else if (bvalid_ff && s_axi_bready) begin
				bvalid_ff <= 1'b0;
			end
		end
	end

	// control register; byte lanes honoured, only writable bits stored
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			ctrl_ff <= PORT_CTRL_RESET;
		end else if (ce) begin
			if (aw_held_ff && w_held_ff && !bvalid_ff && hit(waddr_ff)) begin
				for (int b = 0; b < CTRL_W / 8; b++) begin
					if (wstrb_ff[b]) begin
						// reserved and input positions are dropped here
						ctrl_ff[b*8 +: 8] <= wdata_ff[b*8 +: 8] &
							PORT_CTRL_WR_MASK[b*8 +: 8];
					end
				end
			end
		end
	end

	// read channel: one read at a time, unmapped reads answer slverr
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			arready_ff <= 1'b1;
			rvalid_ff  <= 1'b0;
			rdata_ff   <= '0;
			rresp_ff   <= RESP_OKAY;
		end else if (ce) begin
			if (s_axi_arvalid && arready_ff) begin
				arready_ff <= 1'b0;
				rvalid_ff  <= 1'b1;
				rdata_ff   <= hit(s_axi_araddr) ? rd_word : '0;
				rresp_ff   <= hit(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
			end else if (rvalid_ff && s_axi_rready) begin
				rvalid_ff  <= 1'b0;
				arready_ff <= 1'b1;
			end
		end
	end

	// pin input synchroniser; a change counts once stages two and three agree
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			ps1_ff   <= '0;
			ps2_ff   <= '0;
			ps3_ff   <= '0;
			pfilt_ff <= '0;
		end else if (ce) begin
			ps1_ff <= pin_in;
			ps2_ff <= ps1_ff;
			ps3_ff <= ps2_ff;
			for (int i = 0; i < NPINS; i++) begin
				if (ps2_ff[i] == ps3_ff[i]) begin
					pfilt_ff[i] <= ps3_ff[i];
				end
			end
		end
	end

	// input bits: sampled level in input state unless the pin carries the stream, zero otherwise
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			in_ff <= '0;
		end else if (ce) begin
			for (int i = 0; i < NPINS; i++) begin
				if (ctrl_ff[i*PIN_STRIDE+STATE_OFS +: 2] == PIN_INPUT &&
					!(aux_en && i < AUX_PINS)) begin
					in_ff[i] <= pfilt_ff[i];
				end else begin
					in_ff[i] <= 1'b0;
				end
			end
		end
	end

	// pin 3 never takes part in the stream
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			p3_out_ff  <= 1'b0;
			p3_oe_n_ff <= 1'b1;
		end else if (ce) begin
			{p3_out_ff, p3_oe_n_ff} <= pin_drive(
				ctrl_ff[3*PIN_STRIDE+STATE_OFS +: 2],
				ctrl_ff[3*PIN_STRIDE+OUT_OFS]);
		end
	end

	// ecg word handover: one holding word, toggle request, toggle ack
	always_comb begin
		ecg_take     = ecg_valid && ready_ff;
		nxt_req_tgl  = req_tgl_ff ^ ecg_take;
		nxt_ack_seen = (as2_ff == as3_ff) ? as3_ff : ack_seen_ff;
	end

	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			hold_ff     <= '0;
			req_tgl_ff  <= 1'b0;
			ready_ff    <= 1'b1;
			as1_ff      <= 1'b0;
			as2_ff      <= 1'b0;
			as3_ff      <= 1'b0;
			ack_seen_ff <= 1'b0;
		end else if (ce) begin
			if (ecg_take) begin
				hold_ff <= ecg_data;
			end
			req_tgl_ff  <= nxt_req_tgl;
			as2_ff      <= as1_ff;
			as3_ff      <= as2_ff;
			ack_seen_ff <= nxt_ack_seen;
			// holding word is free again once the link has echoed the toggle
			ready_ff    <= (nxt_req_tgl == nxt_ack_seen);
			as1_ff      <= ack_tgl_ff;
		end
	end

	// configuration handed to the link domain as levels
	always_comb begin
		cfg_src = {ce, ctrl_ff[AUX_FRAMING_BIT], aux_en,
			ctrl_ff[2*PIN_STRIDE+OUT_OFS +: 3],
			ctrl_ff[PIN_STRIDE+OUT_OFS +: 3],
			ctrl_ff[OUT_OFS +: 3]};
	end

	// link-domain state
	logic [CFG_W-1:0]   cs1_ff;
	logic [CFG_W-1:0]   cs2_ff;
	logic [CFG_W-1:0]   cs3_ff;
	logic [CFG_W-1:0]   cfg_ff;
	logic               rs1_ff;
	logic               rs2_ff;
	logic               rs3_ff;
	logic               req_seen_ff;
	logic [WORD_W-1:0]  link_word_ff;
	logic               have_word_ff;
	gpx_lstate_t        lstate_ff;
	logic [RATE_W-1:0]  rate_cnt_ff;
	logic [BIT_W-1:0]   bit_cnt_ff;
	logic [WCNT_W-1:0]  word_cnt_ff;
	logic [GAP_W-1:0]   gap_cnt_ff;
	logic [WORD_W-1:0]  shift_ff;
	logic               sclk_ff;
	logic               csn_ff;
	logic [AUX_PINS-1:0] lpin_out_ff;
	logic [AUX_PINS-1:0] lpin_oe_n_ff;
	logic               l_ce;
	logic               l_fw;
	logic               l_en;
	logic               tick;
	logic               word_end;
	logic               last_word;
	logic               gap_end;
	logic               word_load;
	logic [WORD_W-1:0]  next_word;

	assign l_ce = cfg_ff[CFG_W-1];
	assign l_fw = cfg_ff[CFG_W-2];
	assign l_en = cfg_ff[CFG_W-3];

	// configuration and request synchronisers on the link clock
	always_ff @(posedge link_clk or negedge nrst) begin
		if (!nrst) begin
			cs1_ff      <= '0;
			cs2_ff      <= '0;
			cs3_ff      <= '0;
			cfg_ff      <= '0;
			rs1_ff      <= 1'b0;
			rs2_ff      <= 1'b0;
			rs3_ff      <= 1'b0;
			req_seen_ff <= 1'b0;
		end else begin
			cs1_ff <= cfg_src;
			cs2_ff <= cs1_ff;
			cs3_ff <= cs2_ff;
			rs1_ff <= req_tgl_ff;
			rs2_ff <= rs1_ff;
			rs3_ff <= rs2_ff;
			// whole vector moves only when settled, so fields stay coherent
			if (cs2_ff == cs3_ff) begin
				cfg_ff <= cs3_ff;
			end
			if (rs2_ff == rs3_ff) begin
				req_seen_ff <= rs3_ff;
			end
		end
	end

	// sequencer decode
	always_comb begin
		tick      = (rate_cnt_ff == RATE_W'(RATE_CNT - 1));
		last_word = (word_cnt_ff == WCNT_W'(FRAME_WORDS - 1));
		word_end  = (lstate_ff == LS_SHIFT) && sclk_ff &&
			(bit_cnt_ff == '0);
		gap_end   = (lstate_ff == LS_GAP) &&
			(gap_cnt_ff == GAP_W'(GAP_CYC - 1));
		word_load = l_en && (((lstate_ff == LS_IDLE) && tick) ||
			(word_end && !last_word && !l_fw) || gap_end);
		// an empty slot goes out as zeros rather than stalling the frame
		next_word = have_word_ff ? link_word_ff : '0;
	end

	// link word register: takes a word only when the previous one went out
	always_ff @(posedge link_clk or negedge nrst) begin
		if (!nrst) begin
			link_word_ff <= '0;
			have_word_ff <= 1'b0;
			ack_tgl_ff   <= 1'b0;
		end else if (l_ce) begin
			if (word_load) begin
				have_word_ff <= 1'b0;
			end else if (!have_word_ff && (req_seen_ff != ack_tgl_ff)) begin
				link_word_ff <= hold_ff;
				have_word_ff <= 1'b1;
				ack_tgl_ff   <= req_seen_ff;
			end
		end
	end

	// frame rate divider
	always_ff @(posedge link_clk or negedge nrst) begin
		if (!nrst) begin
			rate_cnt_ff <= '0;
		end else if (l_ce) begin
			rate_cnt_ff <= tick ? '0 : rate_cnt_ff + 1'b1;
		end
	end

	// serial sequencer: data changes on the falling edge of the clock
	always_ff @(posedge link_clk or negedge nrst) begin
		if (!nrst) begin
			lstate_ff   <= LS_IDLE;
			bit_cnt_ff  <= '0;
			word_cnt_ff <= '0;
			gap_cnt_ff  <= '0;
			shift_ff    <= '0;
			sclk_ff     <= 1'b0;
			csn_ff      <= 1'b1;
		end else if (l_ce) begin
			if (!l_en) begin
				lstate_ff <= LS_IDLE;
				sclk_ff   <= 1'b0;
				csn_ff    <= 1'b1;
			end else begin
				case (lstate_ff)
					LS_IDLE: begin
						if (tick) begin
							lstate_ff   <= LS_SHIFT;
							word_cnt_ff <= '0;
							bit_cnt_ff  <= BIT_W'(WORD_W - 1);
							shift_ff    <= next_word;
							csn_ff      <= 1'b0;
						end
					end
					LS_SHIFT: begin
						sclk_ff <= !sclk_ff;
						if (sclk_ff && bit_cnt_ff != '0) begin
							bit_cnt_ff <= bit_cnt_ff - 1'b1;
							shift_ff   <= {shift_ff[WORD_W-2:0], 1'b0};
						end else if (word_end && last_word) begin
							lstate_ff <= LS_IDLE;
							csn_ff    <= 1'b1;
						end else if (word_end && l_fw) begin
							lstate_ff   <= LS_GAP;
							gap_cnt_ff  <= '0;
							csn_ff      <= 1'b1;
							word_cnt_ff <= word_cnt_ff + 1'b1;
						end else if (word_end) begin
							word_cnt_ff <= word_cnt_ff + 1'b1;
							bit_cnt_ff  <= BIT_W'(WORD_W - 1);
							shift_ff    <= next_word;
						end
					end
					LS_GAP: begin
						gap_cnt_ff <= gap_cnt_ff + 1'b1;
						if (gap_end) begin
							lstate_ff  <= LS_SHIFT;
							bit_cnt_ff <= BIT_W'(WORD_W - 1);
							shift_ff   <= next_word;
							csn_ff     <= 1'b0;
						end
					end
					default: begin
						lstate_ff <= LS_IDLE;
						csn_ff    <= 1'b1;
					end
				endcase
			end
		end
	end

	// pins 0-2: stream signals when enabled, own controls otherwise
	always_ff @(posedge link_clk or negedge nrst) begin
		if (!nrst) begin
			lpin_out_ff  <= '0;
			lpin_oe_n_ff <= '1;
		end else if (l_ce) begin
			if (l_en) begin
				// pin0 clock, pin1 data, pin2 select, all driven
				lpin_out_ff  <= {csn_ff, shift_ff[WORD_W-1], sclk_ff};
				lpin_oe_n_ff <= '0;
			end else begin
				for (int i = 0; i < AUX_PINS; i++) begin
					{lpin_out_ff[i], lpin_oe_n_ff[i]} <= pin_drive(
						cfg_ff[i*3+1 +: 2], cfg_ff[i*3]);
				end
			end
		end
	end

	// outputs straight from flops
	assign s_axi_awready = awready_ff;
	assign s_axi_wready  = wready_ff;
	assign s_axi_bvalid  = bvalid_ff;
	assign s_axi_bresp   = bresp_ff;
	assign s_axi_arready = arready_ff;
	assign s_axi_rvalid  = rvalid_ff;
	assign s_axi_rdata   = rdata_ff;
	assign s_axi_rresp   = rresp_ff;
	assign ecg_ready     = ready_ff;
	assign pin_out       = {p3_out_ff, lpin_out_ff};
	assign pin_oe_n      = {p3_oe_n_ff, lpin_oe_n_ff};

endmodule

// ===== bench/gpx_props.sv
// checker: bus timing, reset state and pin drive seen at the port
`timescale 1ns/100ps
module gpx_props
	import gpx_pkg::*;
(
	// clocks and reset
	input wire logic              clock,
	input wire logic              nrst,
	input wire logic              ce,
	input wire logic              link_clk,
	// register bus
	input wire logic [ADDR_W-1:0] s_axi_awaddr,
	input wire logic              s_axi_awvalid,
	input wire logic              s_axi_awready,
	input wire logic [DATA_W-1:0] s_axi_wdata,
	input wire logic [STRB_W-1:0] s_axi_wstrb,
	input wire logic              s_axi_wvalid,
	input wire logic              s_axi_wready,
	input wire logic [1:0]        s_axi_bresp,
	input wire logic              s_axi_bvalid,
	input wire logic              s_axi_bready,
	input wire logic              s_axi_arvalid,
	input wire logic              s_axi_arready,
	input wire logic [DATA_W-1:0] s_axi_rdata,
	input wire logic              s_axi_rvalid,
	input wire logic              s_axi_rready,
	// pins
	input wire logic [NPINS-1:0]  pin_out,
	input wire logic [NPINS-1:0]  pin_oe_n
);
	logic wr_both;
	logic wr_pin3;

	// both write halves taken at one edge; the bench always offers them so
	assign wr_both = s_axi_awvalid && s_axi_awready && s_axi_wvalid
		&& s_axi_wready && ce;
	assign wr_pin3 = wr_both && s_axi_wstrb[1]
		&& s_axi_awaddr[ADDR_W-1:2] == PORT_CTRL_IDX[ADDR_W-3:0];

	// release expected for a state field and output value
	function automatic logic oe_exp(input logic [1:0] st, input logic v);
		return (st == PIN_PUSH) ? 1'b0 : ((st == PIN_DRAIN) ? v : 1'b1);
	endfunction

	wr_resp_a: assert property (@(posedge clock) disable iff (!nrst)
		wr_both |-> ##2 s_axi_bvalid) else $error("write answer late");
	rd_resp_a: assert property (@(posedge clock) disable iff (!nrst)
		s_axi_arvalid && s_axi_arready && ce |=> s_axi_rvalid)
		else $error("read answer late");
	bresp_hold_a: assert property (@(posedge clock) disable iff (!nrst)
		s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
		else $error("write answer dropped");
	rdata_hold_a: assert property (@(posedge clock) disable iff (!nrst)
		s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read answer dropped");
	wr_block_a: assert property (@(posedge clock) disable iff (!nrst)
		s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
		else $error("write accepted while answer pending");
	rst_idle_a: assert property (@(posedge clock) disable iff (!nrst)
		$rose(nrst) |-> pin_oe_n == 4'hF && pin_out == 4'h0
		&& !s_axi_bvalid && !s_axi_rvalid) else $error("not idle after reset");
	pin3_follow_a: assert property (@(posedge clock) disable iff (!nrst)
		wr_pin3 |-> ##3 pin_oe_n[3] == oe_exp($past(s_axi_wdata[15:14], 3),
		$past(s_axi_wdata[13], 3)) && pin_out[3] == ($past(s_axi_wdata[13], 3)
		&& $past(s_axi_wdata[15:14], 3) == PIN_PUSH))
		else $error("pin 3 drive wrong");
	sclk_pulse_a: assert property (@(posedge link_clk) disable iff (!nrst)
		$rose(pin_out[0]) && pin_oe_n[2:0] == 3'h0 |=> !pin_out[0])
		else $error("serial clock high too long");
	sdata_hold_a: assert property (@(posedge link_clk) disable iff (!nrst)
		$rose(pin_out[0]) && pin_oe_n[2:0] == 3'h0 |-> $stable(pin_out[1]))
		else $error("serial data moved at clock rise");

	wr_pin3_c: cover property (@(posedge clock) wr_pin3);
	sclk_c: cover property (@(posedge link_clk) $rose(pin_out[0]));
	refuse_c: cover property (@(posedge clock)
		s_axi_bvalid && s_axi_bresp == RESP_SLVERR);
endmodule

bind gpx_port gpx_props gpx_props_i (.*);

// ===== bench/gpx_far.sv
// far-side model: pin wiring and the serial receiver on pins 0-2
`timescale 1ns/100ps
module gpx_far
	import gpx_pkg::*;
(
	// link clock and reset
	input  wire logic              link_clk,
	input  wire logic              nrst,
	// pins
	input  wire logic [NPINS-1:0]  pin_out,
	input  wire logic [NPINS-1:0]  pin_oe_n,
	input  wire logic [NPINS-1:0]  ext_lvl,
	output logic [NPINS-1:0]       pin_in,
	// receiver results
	output logic [WORD_W-1:0]      rx_word,
	output logic [15:0]            low_len,
	output logic [15:0]            frame_gap
);
	logic [WORD_W-1:0] shift_ff;
	logic [WORD_W-1:0] nxt_shift;
	logic [5:0]        bit_ff;
	logic [15:0]       low_ff;
	logic [15:0]       cyc_ff;
	logic [15:0]       fall_ff;
	logic              sclk_ff;
	logic              sel_ff;
	logic              sel_n;

	// released pin shows the outside level, a driven pin wins
	assign pin_in = (pin_oe_n & ext_lvl) | (~pin_oe_n & pin_out);
	// a released select reads idle, as with a pull-up
	assign sel_n = pin_oe_n[2] | pin_out[2];
	assign nxt_shift = {shift_ff[WORD_W-2:0], pin_out[1]};

	// sample data at each rising serial clock; select high restarts words
	always_ff @(posedge link_clk or negedge nrst) begin
		if (!nrst) begin
			shift_ff <= '0;
			bit_ff <= '0;
			low_ff <= '0;
			cyc_ff <= '0;
			fall_ff <= '0;
			sclk_ff <= 1'b0;
			sel_ff <= 1'b1;
			rx_word <= '0;
			low_len <= '0;
			frame_gap <= '0;
		end else begin
			sclk_ff <= pin_out[0];
			sel_ff <= sel_n;
			cyc_ff <= cyc_ff + 16'h1;
			if (sel_n) begin
				bit_ff <= '0;
				low_ff <= '0;
			end else begin
				low_ff <= low_ff + 16'h1;
				if (pin_out[0] && !sclk_ff) begin
					shift_ff <= nxt_shift;
					bit_ff <= (bit_ff == 6'(WORD_W - 1)) ? 6'h0 : bit_ff + 6'h1;
					if (bit_ff == 6'(WORD_W - 1) && nxt_shift != '0) begin
						rx_word <= nxt_shift;
					end
				end
			end
			if (sel_n && !sel_ff) begin
				low_len <= low_ff;
			end
			if (!sel_n && sel_ff) begin
				frame_gap <= cyc_ff - fall_ff;
				fall_ff <= cyc_ff;
			end
		end
	end
endmodule

// ===== bench/tb.sv
// self-checking bench: register access, pin modes, inputs, serial stream
`timescale 1ns/100ps
module tb;
	import gpx_pkg::*;
	logic              clock, nrst, ce, link_clk;
	logic [ADDR_W-1:0] s_axi_awaddr, s_axi_araddr;
	logic [DATA_W-1:0] s_axi_wdata, s_axi_rdata;
	logic [STRB_W-1:0] s_axi_wstrb;
	logic [1:0]        s_axi_bresp, s_axi_rresp;
	logic              s_axi_awvalid, s_axi_awready, s_axi_wvalid;
	logic              s_axi_wready, s_axi_bvalid, s_axi_bready;
	logic              s_axi_arvalid, s_axi_arready, s_axi_rvalid;
	logic              s_axi_rready, ecg_valid, ecg_ready;
	logic [WORD_W-1:0] ecg_data, rx_word;
	logic [NPINS-1:0]  pin_in, pin_out, pin_oe_n, ext_lvl;
	logic [15:0]       low_len, frame_gap;
	int                num_errors;
	int                compares;

	gpx_port gpx_port_i (.*);
	gpx_far gpx_far_i (.*);

	// main clock
	initial begin
		clock = 1'b0;
		forever #20 clock = ~clock;
	end

	// link clock, offset so its edges never meet the main ones
	initial begin
		link_clk = 1'b0;
		#3;
		forever #7.5 link_clk = ~link_clk;
	end

	task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp) begin
			num_errors++;
			$display("unexpected at %0t: got %h, expected %h", $time, got, exp);
		end
	endtask

	// bready comes late on purpose so the answer must stand
	task automatic axi_wr(input logic [7:0] a, input logic [31:0] d,
		input logic [1:0] er);
		logic aw_ok;
		logic w_ok;
		aw_ok = 1'b0;
		w_ok = 1'b0;
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		while (!(aw_ok && w_ok)) begin
			@(posedge clock);
			if (!aw_ok && s_axi_awready === 1'b1) begin
				aw_ok = 1'b1;
				s_axi_awvalid <= 1'b0;
			end
			if (!w_ok && s_axi_wready === 1'b1) begin
				w_ok = 1'b1;
				s_axi_wvalid <= 1'b0;
			end
		end
		repeat (2) @(posedge clock);
		s_axi_bready <= 1'b1;
		do @(posedge clock); while (s_axi_bvalid !== 1'b1);
		s_axi_bready <= 1'b0;
		cmp(32'(s_axi_bresp), 32'(er));
	endtask

	task automatic axi_rd(input logic [7:0] a, input logic [31:0] exp,
		input logic [1:0] er);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		do @(posedge clock); while (s_axi_arready !== 1'b1);
		s_axi_arvalid <= 1'b0;
		@(posedge clock);
		s_axi_rready <= 1'b1;
		do @(posedge clock); while (s_axi_rvalid !== 1'b1);
		s_axi_rready <= 1'b0;
		cmp(s_axi_rdata, exp);
		cmp(32'(s_axi_rresp), 32'(er));
	endtask

	task automatic t_reset();
		axi_rd(PORT_CTRL_ADDR, 32'h0, RESP_OKAY);
		cmp(32'(pin_oe_n), 32'hF);
		cmp(32'(pin_out), 32'h0);
	endtask

	// every state and value on every pin, the others left released
	task automatic t_modes();
		logic [31:0] d;
		for (int p = 0; p < NPINS; p++) begin
			for (int s = 0; s < 4; s++) begin
				for (int v = 0; v < 2; v++) begin
					d = 32'(((s << STATE_OFS) | (v << OUT_OFS)) << (p * PIN_STRIDE));
					axi_wr(PORT_CTRL_ADDR, d, RESP_OKAY);
					repeat (8) @(posedge clock);
					cmp(32'(pin_oe_n[p]), 32'(s < 2 || (s == 3 && v == 1)));
					cmp(32'(pin_out[p]), 32'(s == 2 && v == 1));
					axi_rd(PORT_CTRL_ADDR, d, RESP_OKAY);
				end
			end
		end
	endtask

	// all pins inputs; ones written to the input bits must not stick
	task automatic t_inputs();
		ext_lvl <= 4'hA;
		axi_wr(PORT_CTRL_ADDR, 32'h5555, RESP_OKAY);
		repeat (10) @(posedge clock);
		axi_rd(PORT_CTRL_ADDR, 32'h5454, RESP_OKAY);
		ext_lvl <= 4'h5;
		repeat (10) @(posedge clock);
		axi_rd(PORT_CTRL_ADDR, 32'h4545, RESP_OKAY);
		// frozen port keeps the old input bits even though the pins moved
		ce <= 1'b0;
		ext_lvl <= 4'hA;
		repeat (10) @(posedge clock);
		ce <= 1'b1;
		axi_rd(PORT_CTRL_ADDR, 32'h4545, RESP_OKAY);
		repeat (10) @(posedge clock);
		axi_rd(PORT_CTRL_ADDR, 32'h5454, RESP_OKAY);
	endtask

	// pins 0-2 left high impedance in their fields, pin 3 pushes high
	task automatic t_stream(input logic fw, input logic [31:0] w);
		ecg_data <= w;
		ecg_valid <= 1'b1;
		do @(posedge clock); while (ecg_ready !== 1'b1);
		ecg_valid <= 1'b0;
		@(negedge clock);
		cmp(32'(ecg_ready), 32'h0);
		@(posedge clock);
		axi_wr(PORT_CTRL_ADDR, 32'h1A000 | 32'(fw) << 18, RESP_OKAY);
		repeat (3 * RATE_CNT * LINK_PERIOD_NS / 40) @(posedge clock);
		cmp(32'(pin_oe_n), 32'h0);
		cmp(32'(pin_out[3]), 32'h1);
		cmp(rx_word, w);
		cmp(32'(ecg_ready), 32'h1);
		cmp(32'(low_len), fw ? 2 * WORD_W : 2 * WORD_W * FRAME_WORDS);
		if (!fw) cmp(32'(frame_gap), RATE_CNT);
		axi_wr(PORT_CTRL_ADDR, 32'h0, RESP_OKAY);
		repeat (8) @(posedge clock);
		cmp(32'(pin_oe_n), 32'hF);
	endtask

	// unmapped places are refused and leave the register alone
	task automatic t_unmapped();
		axi_rd(8'h1C, 32'h0, RESP_SLVERR);
		axi_wr(8'h20, 32'hA000, RESP_SLVERR);
		axi_rd(PORT_CTRL_ADDR, 32'h0, RESP_OKAY);
		// only byte lane one written; its input bits still drop out
		s_axi_wstrb <= 4'h2;
		axi_wr(PORT_CTRL_ADDR, 32'h0000FF00, RESP_OKAY);
		axi_rd(PORT_CTRL_ADDR, 32'hEE00, RESP_OKAY);
		s_axi_wstrb <= 4'hF;
	endtask

	task automatic complete_run();
		$display("compares %0d num_errors %0d", compares, num_errors);
		if (num_errors == 0 && compares > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask

	initial begin
		num_errors = 0;
		compares = 0;
		nrst = 1'b0;
		ce = 1'b1;
		s_axi_awaddr = '0;
		s_axi_araddr = '0;
		s_axi_wdata = '0;
		s_axi_wstrb = 4'hF;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 3'h0;
		{s_axi_arvalid, s_axi_rready, ecg_valid} = 3'h0;
		ecg_data = '0;
		ext_lvl = 4'h0;
		repeat (5) @(posedge clock);
		nrst <= 1'b1;
		@(posedge clock);
		t_reset();
		t_modes();
		t_inputs();
		t_stream(1'b0, 32'hA5C30F96);
		t_stream(1'b1, 32'h3C96A55A);
		t_unmapped();
		complete_run();
	end

	// whole run is near 1800 clocks; the limit of 7500 clocks allows four times that
	initial begin
		#300000;
		num_errors++;
		complete_run();
	end
endmodule
